// File: hdl/ilvl_pkg.sv
package ilvl_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int NLVL = 8;
   localparam int NSRC = 26;
   localparam int SRC_IW = 5;
   localparam int VEC_MAX_PER_LVL = 128;
   localparam int NEVT = 2;

   // ------------------------------------------------------------
   // vector area and boot address
   // ------------------------------------------------------------
   localparam logic [7:0] VEC_BASE = 8'hCC;
   localparam logic [7:0] VEC_LAST = 8'hFE;
   localparam logic [15:0] RESET_PC = 16'h0100;
   localparam logic [NSRC-1:0] AUTOCLR_RST = 26'h00016AC;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_SYSMODE = 8'h00;
   localparam logic [7:0] OFS_LVLMASK = 8'h04;
   localparam logic [7:0] OFS_LVLPRIO = 8'h08;
   localparam logic [7:0] OFS_LVLREQ = 8'h0C;
   localparam logic [7:0] OFS_SRCPEND = 8'h10;
   localparam logic [7:0] OFS_SRCEN = 8'h14;
   localparam logic [7:0] OFS_AUTOCLR = 8'h18;
   localparam logic [7:0] OFS_EVTSTAT = 8'h1C;
   localparam logic [7:0] OFS_EVTCLR = 8'h20;
   localparam logic [7:0] OFS_EVTEN = 8'h24;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SYM_GIE_BIT = 0;
   localparam int EVT_GRANT_BIT = 0;
   localparam int EVT_DONE_BIT = 1;
   localparam int PRIO_GRP_LSB = 0;
   localparam int PRIO_A_BIT = 3;
   localparam int PRIO_B_LSB = 4;
   localparam int PRIO_C_LSB = 6;
   localparam logic [2:0] PRIO_GRP_CODES = 3'h6;
   // group ranks {C,B,A} per order code 5..0
   localparam logic [35:0] GRP_RANK_TBL = 36'h1894A1624;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH_HI,
      ST_FETCH_LO
   } ilvl_state_t;

   // source index to request level
   function automatic logic [2:0] src_lvl(input logic [SRC_IW-1:0] i);
      logic [2:0] l;
      l = 3'h7;
      if (i < 5'h03) l = 3'h0;
      else if (i < 5'h04) l = 3'h1;
      else if (i < 5'h06) l = 3'h2;
      else if (i < 5'h0A) l = 3'h3;
      else if (i < 5'h0E) l = 3'h4;
      else if (i < 5'h12) l = 3'h5;
      else if (i < 5'h16) l = 3'h6;
      return l;
   endfunction

endpackage

// File: hdl/ilvl_low_pick.sv
`timescale 1ns/1ps
module ilvl_low_pick #(
   parameter int W = 26,
   parameter int IW = 5
) (
   input wire logic [W-1:0] i_vec,
   output logic o_any,
   output logic [IW-1:0] o_idx
);

   // lowest set bit wins
   always_comb begin
      o_any = |i_vec;
      o_idx = '0;
      for (int i = W - 1; i >= 0; i--) begin
         if (i_vec[i]) begin
            o_idx = IW'(i);
         end
      end
   end

endmodule

// File: hdl/ilvl_prio_res.sv
`timescale 1ns/1ps
module ilvl_prio_res
   import ilvl_pkg::*;
(
   input wire logic [NLVL-1:0] i_req,
   input wire logic [7:0] i_prio,
   output logic o_valid,
   output logic [2:0] o_level
);

   // rank of a level, 0 is highest
   function automatic logic [3:0] lvl_rank(input logic [2:0] l, input logic [7:0] p);
      logic [2:0] code;
      logic [1:0] grp;
      logic [1:0] pos;
      logic [1:0] top;
      logic [1:0] sub;
      logic [5:0] rk;
      code = p[PRIO_GRP_LSB +: 3];
      if (code >= PRIO_GRP_CODES) code = 3'h0;
      rk = GRP_RANK_TBL[6 * code +: 6];
      if (l < 3'h2) begin
         grp = 2'h0;
         pos = 2'(l);
         sub = {1'b0, pos[0] ^ p[PRIO_A_BIT]};
      end else begin
         if (l < 3'h5) begin
            grp = 2'h1;
            pos = 2'(l - 3'h2);
            top = p[PRIO_B_LSB +: 2];
         end else begin
            grp = 2'h2;
            pos = 2'(l - 3'h5);
            top = p[PRIO_C_LSB +: 2];
         end
         if (top == 2'h3) top = 2'h0;
         sub = 2'((3'(pos) + 3'h3 - 3'(top)) % 3'h3);
      end
      return 4'(rk[2 * grp +: 2]) * 4'h3 + 4'(sub);
   endfunction

   always_comb begin
      logic [3:0] best;
      logic [3:0] rk;
      best = 4'hF;
      rk = 4'h0;
      o_valid = 1'b0;
      o_level = 3'h0;
      for (int l = 0; l < NLVL; l++) begin
         rk = lvl_rank(3'(l), i_prio);
         if (i_req[l] && rk < best) begin
            best = rk;
            o_valid = 1'b1;
            o_level = 3'(l);
         end
      end
   end

endmodule

// File: hdl/ilvl_ctrl.sv
// Functional notes
// - eight request levels, every source on one
// - level order only from priority register
// - up to 128 vectors per level, 26 here
// - lowest vector wins within a level
// - grant masks all, pushes pc and flags
// - service address is two vector bytes
// - vectors live in first 256 bytes
// - execution starts at 0100 hex after reset
// - enable and mask opcodes drive mode bit 0
// - enabled: pending requests served in priority order
// - pending cleared by hardware or by software
// - one-level one-vector types, one source each
// - each of 26 sources has own vector
// - per-level mask register
// - request register shows one flag per level
// - three groups: 0-1, 2-4, 5-7
`timescale 1ns/1ps
module ilvl_ctrl
   import ilvl_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [NSRC-1:0] i_src_evt,
   input wire logic i_gie_set,
   input wire logic i_gie_clr,
   input wire logic i_int_ack,
   input wire logic i_fetch_valid,
   input wire logic [7:0] i_fetch_data,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic i_hready,
   input wire logic [31:0] i_hwdata,
   output logic o_int_req,
   output logic o_push_ctx,
   output logic o_fetch_req,
   output logic [7:0] o_fetch_addr,
   output logic [15:0] o_pc,
   output logic o_pc_load,
   output logic o_evt_irq,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic gie;
      logic [NLVL-1:0] lvl_mask;
      logic [7:0] lvl_prio;
      logic [NSRC-1:0] src_pend;
      logic [NSRC-1:0] src_en;
      logic [NSRC-1:0] auto_clr;
      logic [NEVT-1:0] evt_stat;
      logic [NEVT-1:0] evt_en;
      ilvl_state_t st;
      logic [SRC_IW-1:0] sel_src;
      logic [7:0] hi_byte;
      logic [7:0] fetch_addr;
      logic [15:0] pc;
      logic pc_load;
      logic push;
      logic dph_wr;
      logic [7:0] dph_addr;
      logic [31:0] rdata;
   } ilvl_st_t;

   localparam ilvl_st_t RST_STATE = '{
      gie: 1'b0,
      lvl_mask: '0,
      lvl_prio: '0,
      src_pend: '0,
      src_en: '0,
      auto_clr: AUTOCLR_RST,
      evt_stat: '0,
      evt_en: '0,
      st: ST_IDLE,
      sel_src: '0,
      hi_byte: '0,
      fetch_addr: '0,
      pc: RESET_PC,
      pc_load: 1'b1,
      push: 1'b0,
      dph_wr: 1'b0,
      dph_addr: '0,
      rdata: '0
   };

   ilvl_st_t s_r;
   ilvl_st_t s_nxt;

   logic [NSRC-1:0] elig;
   logic [NLVL-1:0] lvl_raw;
   logic [NLVL-1:0] lvl_req;
   logic [NSRC-1:0] cand;
   logic win_ok;
   logic [2:0] win_lvl;
   logic pick_any;
   logic [SRC_IW-1:0] pick_idx;
   logic [7:0] win_vec;
   logic grant;

   // ------------------------------------------------------------
   // level requests
   // ------------------------------------------------------------
   always_comb begin
      elig = s_r.src_pend & s_r.src_en;
      lvl_raw = '0;
      cand = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (elig[i]) begin
            lvl_raw[src_lvl(SRC_IW'(i))] = 1'b1;
         end
         cand[i] = elig[i] && (src_lvl(SRC_IW'(i)) == win_lvl);
      end
      lvl_req = lvl_raw & s_r.lvl_mask & {NLVL{s_r.gie}};
   end

   ilvl_prio_res u_res (
      .i_req(lvl_req),
      .i_prio(s_r.lvl_prio),
      .o_valid(win_ok),
      .o_level(win_lvl)
   );

   ilvl_low_pick #(
      .W(NSRC),
      .IW(SRC_IW)
   ) u_pick (
      .i_vec(cand),
      .o_any(pick_any),
      .o_idx(pick_idx)
   );

   assign win_vec = VEC_BASE + (8'(pick_idx) << 1);
   assign o_int_req = win_ok && pick_any && (s_r.st == ST_IDLE);
   assign grant = o_int_req && i_int_ack;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic ap;
      logic wr;
      logic [NSRC-1:0] sw_clr;
      logic [NSRC-1:0] hw_clr;
      logic [NEVT-1:0] evt_set;
      logic [NEVT-1:0] evt_clr;
      s_nxt = s_r;
      ap = i_hsel && i_htrans[1] && i_hready;
      wr = s_r.dph_wr;
      sw_clr = '0;
      hw_clr = '0;
      evt_set = '0;
      evt_clr = '0;
      s_nxt.pc_load = 1'b0;
      s_nxt.push = 1'b0;

      // bus writes in the data phase
      if (wr) begin
         case (s_r.dph_addr)
            OFS_SYSMODE: s_nxt.gie = i_hwdata[SYM_GIE_BIT];
            OFS_LVLMASK: s_nxt.lvl_mask = i_hwdata[NLVL-1:0];
            OFS_LVLPRIO: s_nxt.lvl_prio = i_hwdata[7:0];
            OFS_SRCPEND: sw_clr = i_hwdata[NSRC-1:0];
            OFS_SRCEN: s_nxt.src_en = i_hwdata[NSRC-1:0];
            OFS_AUTOCLR: s_nxt.auto_clr = i_hwdata[NSRC-1:0];
            OFS_EVTCLR: evt_clr = i_hwdata[NEVT-1:0];
            OFS_EVTEN: s_nxt.evt_en = i_hwdata[NEVT-1:0];
            default: ;
         endcase
      end

      if (i_gie_clr) begin
         s_nxt.gie = 1'b0;
      end else if (i_gie_set) begin
         s_nxt.gie = 1'b1;
      end

      case (s_r.st)
         ST_IDLE: begin
            if (grant) begin
               s_nxt.gie = 1'b0;
               s_nxt.push = 1'b1;
               s_nxt.sel_src = pick_idx;
               s_nxt.fetch_addr = win_vec;
               s_nxt.st = ST_FETCH_HI;
               evt_set[EVT_GRANT_BIT] = 1'b1;
               hw_clr = s_r.auto_clr & (NSRC'(1) << pick_idx);
            end
         end
         ST_FETCH_HI: begin
            if (i_fetch_valid) begin
               s_nxt.hi_byte = i_fetch_data;
               s_nxt.fetch_addr = s_r.fetch_addr + 8'h01;
               s_nxt.st = ST_FETCH_LO;
            end
         end
         ST_FETCH_LO: begin
            if (i_fetch_valid) begin
               s_nxt.pc = {s_r.hi_byte, i_fetch_data};
               s_nxt.pc_load = 1'b1;
               s_nxt.st = ST_IDLE;
               evt_set[EVT_DONE_BIT] = 1'b1;
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase

      // set wins over clear
      s_nxt.src_pend = (s_r.src_pend & ~sw_clr & ~hw_clr) | i_src_evt;
      s_nxt.evt_stat = (s_r.evt_stat & ~evt_clr) | evt_set;

      // address phase capture and read data
      s_nxt.dph_wr = ap && i_hwrite;
      if (ap) begin
         s_nxt.dph_addr = i_haddr[7:0];
      end
      if (ap && !i_hwrite) begin
         s_nxt.rdata = '0;
         if (i_haddr[31:8] == 24'h000000) begin
            case (i_haddr[7:0])
               OFS_SYSMODE: s_nxt.rdata[SYM_GIE_BIT] = s_nxt.gie;
               OFS_LVLMASK: s_nxt.rdata[NLVL-1:0] = s_nxt.lvl_mask;
               OFS_LVLPRIO: s_nxt.rdata[7:0] = s_nxt.lvl_prio;
               OFS_LVLREQ: s_nxt.rdata[NLVL-1:0] = lvl_raw;
               OFS_SRCPEND: s_nxt.rdata[NSRC-1:0] = s_nxt.src_pend;
               OFS_SRCEN: s_nxt.rdata[NSRC-1:0] = s_nxt.src_en;
               OFS_AUTOCLR: s_nxt.rdata[NSRC-1:0] = s_nxt.auto_clr;
               OFS_EVTSTAT: s_nxt.rdata[NEVT-1:0] = s_nxt.evt_stat;
               OFS_EVTEN: s_nxt.rdata[NEVT-1:0] = s_nxt.evt_en;
               default: s_nxt.rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r <= RST_STATE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_push_ctx = s_r.push;
   assign o_fetch_req = (s_r.st == ST_FETCH_HI) || (s_r.st == ST_FETCH_LO);
   assign o_fetch_addr = s_r.fetch_addr;
   assign o_pc = s_r.pc;
   assign o_pc_load = s_r.pc_load;
   assign o_evt_irq = |(s_r.evt_stat & s_r.evt_en);
   assign o_hrdata = s_r.rdata;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   logic ast_boot_r;
   logic [NSRC-1:0] ast_lower;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ast_boot_r <= 1'b1;
      end else begin
         ast_boot_r <= 1'b0;
      end
   end

   assign ast_lower = cand & ((NSRC'(1) << pick_idx) - NSRC'(1));

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_grant;
      o_int_req && i_int_ack;
   endsequence

   sequence s_lo_take;
      (s_r.st == ST_FETCH_LO) && i_fetch_valid;
   endsequence

   AST_BOOT_PC: assert property (ast_boot_r |-> o_pc_load && o_pc == RESET_PC)
      else $error("boot address not presented");
   AST_LEVEL_GATE: assert property (o_int_req |-> s_r.gie && s_r.lvl_mask[win_lvl])
      else $error("request without global enable or unmask");
   AST_MASKED_LVL: assert property (o_int_req |-> lvl_req[win_lvl])
      else $error("winning level not requesting");
   AST_GIE_OFF: assert property (!s_r.gie |-> !o_int_req)
      else $error("request while globally masked");
   AST_LOWEST_VEC: assert property (o_int_req |-> ast_lower == '0)
      else $error("lower vector pending in same level");
   AST_VEC_AREA: assert property (o_int_req |-> win_vec >= VEC_BASE
      && win_vec <= VEC_LAST && !win_vec[0])
      else $error("vector outside vector area");
   AST_GRANT_SEQ: assert property (s_grant |=> o_push_ctx && !s_r.gie && o_fetch_req
      && o_fetch_addr == $past(win_vec))
      else $error("grant did not mask, push and fetch");
   AST_NO_REGRANT: assert property (s_grant |=> !o_int_req [*2])
      else $error("second request during vector fetch");
   AST_VEC_JOIN: assert property (s_lo_take |=> o_pc_load
      && o_pc == {$past(s_r.hi_byte), $past(i_fetch_data)})
      else $error("service address not formed from vector bytes");
   AST_AUTO_CLR: assert property (s_grant and (s_r.auto_clr[pick_idx]
      && !i_src_evt[pick_idx]) |=> !s_r.src_pend[s_r.sel_src])
      else $error("pending not cleared on service");
   AST_EVT_SET: assert property (s_grant |=> s_r.evt_stat[EVT_GRANT_BIT])
      else $error("grant event lost");
   AST_SRC_LEVEL: assert property (o_int_req |-> src_lvl(pick_idx) == win_lvl)
      else $error("picked source outside winning level");
   AST_SRC_RANGE: assert property (o_int_req |-> 32'(pick_idx) < NSRC
      && NSRC <= VEC_MAX_PER_LVL)
      else $error("picked source beyond implemented vectors");
   AST_GROUP_A_FIRST: assert property (o_int_req && s_r.lvl_prio == 8'h00
      && (|lvl_req[1:0]) |-> win_lvl < 3'h2)
      else $error("first group lost under default order");

endmodule

// File: tb/ilvl_cpu_model.sv
`timescale 1ns/1ps
module ilvl_cpu_model (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ack_en,
   input wire logic [3:0] i_delay,
   input wire logic i_fetch_req,
   input wire logic [7:0] i_fetch_addr,
   output logic o_int_ack,
   output logic o_fetch_valid,
   output logic [7:0] o_fetch_data
);
   logic [3:0] wait_r;

   // ------------------------------------------------------------
   // program memory image
   // ------------------------------------------------------------
   // high byte first
   function automatic logic [7:0] rom_byte(input logic [7:0] a);
      return a[0] ? ~{a[7:1], 1'b0} : a ^ 8'h3C;
   endfunction

   // ------------------------------------------------------------
   // grant and fetch answers
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_int_ack <= 1'b0;
         o_fetch_valid <= 1'b0;
         o_fetch_data <= 8'h00;
         wait_r <= 4'h0;
      end else begin
         o_int_ack <= i_ack_en;
         if (i_fetch_req && !o_fetch_valid && wait_r == i_delay) begin
            o_fetch_valid <= 1'b1;
            o_fetch_data <= rom_byte(i_fetch_addr);
            wait_r <= 4'h0;
         end else begin
            o_fetch_valid <= 1'b0;
            // stale byte is not held
            o_fetch_data <= ~o_fetch_data;
            if (i_fetch_req && !o_fetch_valid) begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule

// File: tb/ilvl_ctrl_tb_top.sv
`timescale 1ns/1ps
module ilvl_ctrl_tb_top;
   import ilvl_pkg::*;
   typedef struct packed {
      logic [4:0] src;
      logic [7:0] vec;
      logic pend;
   } ilvl_row_t;
   localparam ilvl_row_t ROWS [6] = '{'{5'h00, 8'hCC, 1'b1}, '{5'h02, 8'hD0, 1'b0},
      '{5'h03, 8'hD2, 1'b0}, '{5'h09, 8'hDE, 1'b0}, '{5'h0D, 8'hE6, 1'b1},
      '{5'h19, 8'hFE, 1'b1}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [25:0] evt = '0;
   logic gset = 1'b0;
   logic gclr = 1'b0;
   logic ack_en = 1'b0;
   logic [3:0] dly = 4'h0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = '0;
   logic ack, fval, freq, push, int_req, pc_load, evt_irq, hready, hresp;
   logic [7:0] fdata, faddr;
   logic [15:0] pc;
   logic [31:0] hrdata, q;
   int err_total = 0;
   int num_checks = 0;

   always #2 clk = ~clk;

   ilvl_ctrl dut_u (.i_core_clk(clk), .i_rst(rst), .i_src_evt(evt), .i_gie_set(gset),
      .i_gie_clr(gclr), .i_int_ack(ack), .i_fetch_valid(fval), .i_fetch_data(fdata),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(hsize), .i_hready(hready), .i_hwdata(hwdata), .o_int_req(int_req),
      .o_push_ctx(push), .o_fetch_req(freq), .o_fetch_addr(faddr), .o_pc(pc),
      .o_pc_load(pc_load), .o_evt_irq(evt_irq), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(hresp));

   ilvl_cpu_model cpu_u (.i_core_clk(clk), .i_rst(rst), .i_ack_en(ack_en),
      .i_delay(dly), .i_fetch_req(freq), .i_fetch_addr(faddr), .o_int_ack(ack),
      .o_fetch_valid(fval), .o_fetch_data(fdata));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            err_total++;
            tally_and_finish();
         end
         @(posedge clk);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
      chk("hresp", 32'h0, hresp);
   endtask

   task automatic pulse(input logic [25:0] m);
      evt <= m;
      @(posedge clk);
      evt <= '0;
   endtask

   task automatic gie_on();
      gset <= 1'b1;
      @(posedge clk);
      gset <= 1'b0;
   endtask

   task automatic quiet(input string nm);
      repeat (6) begin
         @(posedge clk);
         chk(nm, 32'h0, int_req);
      end
   endtask

   task automatic serve(input string nm, input logic [7:0] v);
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      while (pc_load !== 1'b1) begin
         @(posedge clk);
         if (push === 1'b1) begin
            seen = 1'b1;
            chk(nm, v, faddr);
         end
         n++;
         if (n > 200) begin
            err_total++;
            tally_and_finish();
         end
      end
      chk("push_ctx", 32'h1, seen);
      chk("svc_addr", {v ^ 8'h3C, ~v}, pc);
   endtask

   task automatic pair(input logic [7:0] p, input logic [25:0] m, input logic [7:0] v1,
      input logic [25:0] c1, input logic [7:0] v2);
      wr(OFS_LVLPRIO, {24'h0, p});
      pulse(m);
      gie_on();
      serve("pair_first", v1);
      wr(OFS_SRCPEND, {6'h0, c1});
      gie_on();
      serve("pair_second", v2);
      wr(OFS_SRCPEND, 32'h3FFFFFF);
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      chk("pc_load_rst", 32'h1, pc_load);
      rst <= 1'b0;
      hsel <= 1'b1;
      @(posedge clk);
      chk("pc_rst", RESET_PC, pc);
      rd("autoclr_rst", OFS_AUTOCLR, 32'h16AC);
      rd("sysmode_rst", OFS_SYSMODE, 32'h0);
      rd("unmapped", 8'h40, 32'h0);
      wr(OFS_SRCEN, 32'h3FFFFFF);
      wr(OFS_LVLMASK, 32'hFF);
      wr(OFS_EVTEN, 32'h1);
      ack_en <= 1'b1;
      foreach (ROWS[i]) begin
         dly <= 4'(i * 3);
         pulse(26'h1 << ROWS[i].src);
         gie_on();
         serve("row_vec", ROWS[i].vec);
         rd("gie_after", OFS_SYSMODE, 32'h0);
         rd("pend_after", OFS_SRCPEND, {31'h0, ROWS[i].pend} << ROWS[i].src);
         wr(OFS_SRCPEND, 32'h3FFFFFF);
      end
      pulse(26'hC0);
      gie_on();
      serve("same_lvl", 8'hD8);
      wr(OFS_SRCPEND, 32'h40);
      gie_on();
      serve("next_pend", 8'hDA);
      for (int k = 0; k < 2; k++) begin
         wr(OFS_LVLPRIO, k ? 32'h0 : 32'h4);
         pulse(26'h4001);
         rd("lvl_req", OFS_LVLREQ, 32'h21);
         gie_on();
         serve("prio_first", k ? 8'hCC : 8'hE8);
         wr(OFS_SRCPEND, k ? 32'h1 : 32'h4000);
         gie_on();
         serve("prio_second", k ? 8'hE8 : 8'hCC);
         wr(OFS_SRCPEND, 32'h3FFFFFF);
      end
      pair(8'h08, 26'h0000009, 8'hD2, 26'h0000008, 8'hCC);
      pair(8'h40, 26'h0044000, 8'hF0, 26'h0040000, 8'hE8);
      pair(8'h05, 26'h0000011, 8'hD4, 26'h0000010, 8'hCC);
      wr(OFS_LVLMASK, 32'hFE);
      pulse(26'h1);
      gie_on();
      quiet("masked");
      wr(OFS_LVLMASK, 32'hFF);
      serve("unmasked", 8'hCC);
      ack_en <= 1'b0;
      gie_on();
      rd("sysmode_set", OFS_SYSMODE, 32'h1);
      chk("req_up", 32'h1, int_req);
      gclr <= 1'b1;
      @(posedge clk);
      gclr <= 1'b0;
      quiet("gie_off");
      rd("sysmode_clr", OFS_SYSMODE, 32'h0);
      wr(OFS_SRCEN, 32'h0);
      gie_on();
      quiet("src_off");
      wr(OFS_SRCEN, 32'h3FFFFFF);
      ack_en <= 1'b1;
      serve("resume", 8'hCC);
      rd("evt_stat", OFS_EVTSTAT, 32'h3);
      chk("evt_irq", 32'h1, evt_irq);
      wr(OFS_EVTEN, 32'h0);
      @(posedge clk);
      chk("evt_mask", 32'h0, evt_irq);
      wr(OFS_EVTCLR, 32'h3);
      rd("evt_clr", OFS_EVTSTAT, 32'h0);
      rst <= 1'b1;
      @(posedge clk);
      chk("pc_mid_rst", RESET_PC, pc);
      chk("pcld_mid_rst", 32'h1, pc_load);
      rst <= 1'b0;
      @(posedge clk);
      rd("pend_mid_rst", OFS_SRCPEND, 32'h0);
      rd("sysmode_mid_rst", OFS_SYSMODE, 32'h0);
      tally_and_finish();
   end
endmodule
